// ---- rtl/dsr_ctrl.v ----
// Speed-reference selection, limiting, ramp and start/stop sequencing.
// Assumes APB from a 10 MHz domain; analog and PID values on this clock.
`timescale 1ns/1ps
`include "dsr_defines.vh"
module dsr_ctrl #(
	parameter TENTH_CYCLES = `DSR_TENTH_CYCLES,
	parameter PID_PRESENT  = 1
) (
	// Clock and reset.
	input  wire               ref_clk_i,
	input  wire               rst_n_i,
	// APB slave.
	input  wire               psel_i,
	input  wire               penable_i,
	input  wire               pwrite_i,
	input  wire [7:0]         paddr_i,
	input  wire [31:0]        pwdata_i,
	output wire               pready_o,
	output wire               pslverr_o,
	output reg  [31:0]        prdata_o,
	// Terminals, asynchronous.
	input  wire               run_i,
	input  wire               rev_i,
	input  wire               jog_i,
	input  wire               ai1_sel_i,
	input  wire               step_en_i,
	input  wire               speed_up_i,
	input  wire               speed_down_i,
	// Analog and PID, signed 0.1 % units.
	input  wire signed [15:0] panel_pot_i,
	input  wire signed [15:0] analog_input_one_i,
	input  wire signed [15:0] analog_input_two_i,
	input  wire signed [15:0] pid_out_i,
	// Power stage.
	output reg  signed [15:0] pid_feedback_o,
	output reg  [15:0]        out_freq_o,
	output reg                dir_rev_o,
	output reg                drive_en_o,
	output reg                dc_brake_o,
	output reg                calib_o,
	output reg  [15:0]        brake_current_o
);
	localparam S_IDLE  = 6'h01;
	localparam S_CALIB = 6'h02;
	localparam S_PRE   = 6'h04;
	localparam S_RUN   = 6'h08;
	localparam S_DECEL = 6'h10;
	localparam S_SBRK  = 6'h20;

	function [15:0] umin;
		input [15:0] a;
		input [15:0] b;
		umin = (a < b) ? a : b;
	endfunction

	function [15:0] pct_of;
		input [15:0] base;
		input [15:0] pct;
		reg   [31:0] p;
		begin
			p = base * pct;
			p = p / 32'd1000;
			pct_of = p[15:0];
		end
	endfunction

	function signed [18:0] scale;
		input signed [15:0] p;
		input        [15:0] fmax;
		reg   signed [15:0] c;
		reg   signed [35:0] m;
		begin
			c = (p > 16'sd1000) ? 16'sd1000 : ((p < -16'sd1000) ? -16'sd1000 : p);
			m = c * $signed({2'b00, fmax});
			m = m / 36'sd1000;
			scale = m[18:0];
		end
	endfunction

	// ****************************************
	// Registers and APB slave.
	// ****************************************
	reg [3:0]  src_q;
	reg [1:0]  start_q;
	reg [1:0]  stop_q;
	reg [1:0]  dir_q;
	reg [15:0] floor_q;
	reg [15:0] ceil_q;
	reg [15:0] rated_f_q;
	reg [15:0] rated_i_q;
	reg [15:0] pre_t_q;
	reg [15:0] pre_i_q;
	reg [15:0] stp_t_q;
	reg [15:0] stp_i_q;
	reg [15:0] acc_t_q;
	reg [15:0] dec_t_q;
	reg [15:0] master_q;
	reg [15:0] jog_q;
	reg [15:0] step_q;
	reg [15:0] updn_q;
	reg [15:0] ref_q;
	reg [5:0]  st_q;
	reg        rev_run_q;
	reg [15:0] fcap;
	reg [15:0] fscale;
	reg [15:0] ceil_eff;
	reg [18:0] fcap6;
	reg        mapped;
	reg [31:0] rd;
	wire [15:0] wlo = pwdata_i[15:0];
	wire [15:0] whi = pwdata_i[31:16];
	wire        wr  = psel_i & penable_i & pwrite_i;

	assign pready_o  = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~mapped;

	always @* begin
		fcap6 = {3'b000, rated_f_q} * 19'd6;
		fcap = (fcap6 > {3'b000, `DSR_MAX_HZ}) ? `DSR_MAX_HZ : fcap6[15:0]; // [R21]
		fscale = umin(fcap, ceil_q); // [R5]
		ceil_eff = umin(ceil_q, fcap); // [R21]
	end

	always @* begin
		mapped = 1'b1;
		rd = 32'h00000000;
		case (paddr_i)
			`DSR_OFF_CFG:      rd = {22'h0, dir_q, stop_q, start_q, src_q};
			`DSR_OFF_LIMIT:    rd = {ceil_q, floor_q};
			`DSR_OFF_MOTOR:    rd = {rated_i_q, rated_f_q};
			`DSR_OFF_PRESTART: rd = {pre_i_q, pre_t_q};
			`DSR_OFF_STOPBRK:  rd = {stp_i_q, stp_t_q};
			`DSR_OFF_RAMP:     rd = {dec_t_q, acc_t_q};
			`DSR_OFF_SPEED:    rd = {jog_q, master_q};
			`DSR_OFF_STEP:     rd = {16'h0000, step_q};
			`DSR_OFF_CTRL:     rd = 32'h00000000;
			`DSR_OFF_STATUS:   rd = {out_freq_o, 9'h000, rev_run_q, st_q};
			`DSR_OFF_REF:      rd = {ref_q, updn_q};
			default:           mapped = 1'b0;
		endcase
	end

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h00000000;
			src_q <= `DSR_RST_SRC;
			start_q <= `DSR_RST_START;
			stop_q <= `DSR_RST_STOP; // [R13]
			dir_q <= `DSR_RST_DIR; // [R16]
			floor_q <= `DSR_RST_FLOOR;
			ceil_q <= `DSR_RST_CEIL;
			rated_f_q <= `DSR_RST_RATED_F;
			rated_i_q <= `DSR_RST_RATED_I;
			pre_t_q <= `DSR_RST_BRK_T; // [R9]
			pre_i_q <= `DSR_RST_BRK_I; // [R10]
			stp_t_q <= `DSR_RST_BRK_T; // [R15]
			stp_i_q <= `DSR_RST_BRK_I; // [R15]
			acc_t_q <= `DSR_RST_RAMP_T;
			dec_t_q <= `DSR_RST_RAMP_T;
			master_q <= `DSR_RST_MASTER;
			jog_q <= `DSR_RST_JOG;
			step_q <= 16'h0000;
		end else begin
			if (psel_i & ~penable_i)
				prdata_o <= rd;
			if (wr) begin
				case (paddr_i)
					`DSR_OFF_CFG: begin
						src_q <= (pwdata_i[3:0] > 4'h8) ? src_q : pwdata_i[3:0];
						start_q <= (pwdata_i[5:4] == 2'h3) ? start_q : pwdata_i[5:4];
						stop_q <= (pwdata_i[7:6] == 2'h3) ? stop_q : pwdata_i[7:6];
						dir_q <= pwdata_i[9:8]; // [R16]
					end
					`DSR_OFF_LIMIT: begin
						floor_q <= umin(wlo, `DSR_MAX_FLOOR); // [R19]
						ceil_q <= umin(whi, fcap); // [R21]
					end
					`DSR_OFF_MOTOR: begin
						rated_f_q <= wlo;
						rated_i_q <= whi;
					end
					`DSR_OFF_PRESTART: begin
						pre_t_q <= umin(wlo, `DSR_MAX_TIME); // [R9]
						pre_i_q <= umin(whi, `DSR_MAX_PCT); // [R10]
					end
					`DSR_OFF_STOPBRK: begin
						stp_t_q <= umin(wlo, `DSR_MAX_TIME); // [R15]
						stp_i_q <= umin(whi, `DSR_MAX_PCT); // [R15]
					end
					`DSR_OFF_RAMP: begin
						acc_t_q <= (wlo == 16'h0000) ? 16'h0001 : wlo;
						dec_t_q <= (whi == 16'h0000) ? 16'h0001 : whi;
					end
					`DSR_OFF_SPEED: begin
						master_q <= umin(wlo, fcap); // [R21]
						jog_q <= umin(whi, fcap); // [R21]
					end
					`DSR_OFF_STEP: step_q <= umin(wlo, fcap); // [R21]
					`DSR_OFF_CTRL: if (pwdata_i[0])
						ceil_q <= fcap; // [R22]
					default: ;
				endcase
			end
		end
	end

	// ****************************************
	// Terminal synchronisers and tenth-second tick.
	// ****************************************
	reg [6:0]  pin_m_q;
	reg [6:0]  pin_s_q;
	reg [31:0] pre_cnt_q;
	reg [15:0] tmr_q;
	wire       run_s = pin_s_q[0];
	wire       tick  = (pre_cnt_q == TENTH_CYCLES - 1);

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pin_m_q <= 7'h00;
			pin_s_q <= 7'h00;
		end else begin
			pin_m_q <= {speed_down_i, speed_up_i, step_en_i, ai1_sel_i, jog_i, rev_i, run_i};
			pin_s_q <= pin_m_q;
		end
	end

	// ****************************************
	// Reference selection and limiting.
	// ****************************************
	reg signed [18:0] ai1_f;
	reg signed [18:0] ai2_f;
	reg signed [18:0] sel_s;
	reg        [18:0] mag;
	reg               want_rev;

	always @* begin
		ai1_f = scale(analog_input_one_i, fscale); // [R5]
		ai2_f = scale(analog_input_two_i, fscale);
		case (src_q)
			4'h0: sel_s = {3'b000, master_q};
			4'h1: sel_s = scale(panel_pot_i, fscale);
			4'h2: sel_s = ai1_f;
			4'h3: sel_s = ai2_f;
			4'h4: sel_s = ai1_f + ai2_f; // [R18]
			4'h5: sel_s = (ai1_f > ai2_f) ? ai1_f : ai2_f; // [R1]
			4'h6: sel_s = (ai1_f < ai2_f) ? ai1_f : ai2_f; // [R2]
			4'h7: sel_s = (PID_PRESENT != 0) ? scale(pid_out_i, fscale) : 19'sd0; // [R3]
			4'h8: sel_s = {3'b000, updn_q}; // [R4]
			default: sel_s = 19'sd0;
		endcase
		if (pin_s_q[4])
			sel_s = {3'b000, step_q}; // [R23]
		if (pin_s_q[3])
			sel_s = ai1_f; // [R23]
		if (pin_s_q[2])
			sel_s = {3'b000, jog_q}; // [R23]
		if (sel_s < 0 && dir_q != 2'h3)
			sel_s = 19'sd0; // [R18]
		mag = (sel_s < 0) ? -sel_s : sel_s;
		case (dir_q)
			2'h0: want_rev = pin_s_q[1]; // [R16]
			2'h1: want_rev = 1'b0; // [R16]
			2'h2: want_rev = 1'b1; // [R16]
			default: want_rev = sel_s < 0; // [R17]
		endcase
		// Floor first, then ceiling, so a misordered pair yields the ceiling.
		if (mag < {3'b000, floor_q})
			mag = {3'b000, floor_q}; // [R19] [R20]
		if (mag > {3'b000, ceil_eff})
			mag = {3'b000, ceil_eff}; // [R19] [R25]
	end

	// ****************************************
	// Start/stop sequencer and ramp.
	// ****************************************
	reg  [47:0] acc_q;
	wire [47:0] ramp_lim = ((st_q == S_RUN) ? acc_t_q : dec_t_q) * TENTH_CYCLES; // [R24]
	wire [47:0] acc_nx   = acc_q + {32'h0, rated_f_q}; // [R24]
	wire [15:0] target   = (st_q == S_RUN && want_rev == rev_run_q) ? ref_q : 16'h0000;

	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			st_q <= S_IDLE;
			ref_q <= 16'h0000;
			updn_q <= 16'h0000;
			pre_cnt_q <= 32'h0;
			tmr_q <= 16'h0000;
			acc_q <= 48'h0;
			out_freq_o <= 16'h0000;
			rev_run_q <= 1'b0;
		end else begin
			ref_q <= mag[15:0]; // [R25]
			pre_cnt_q <= tick ? 32'h0 : pre_cnt_q + 32'h1;
			if (tick)
				tmr_q <= tmr_q + 16'h0001;
			// Outside source 8 the up/down value follows the master speed, so
			// the terminals always move the master reference from where it stands.
			if (src_q != 4'h8) begin
				updn_q <= master_q; // [R4]
			end else if (tick) begin
				if (pin_s_q[5] && updn_q < ceil_eff)
					updn_q <= umin(updn_q + `DSR_UPDN_STEP, ceil_eff); // [R4]
				else if (pin_s_q[6])
					updn_q <= (updn_q > `DSR_UPDN_STEP) ? updn_q - `DSR_UPDN_STEP : 16'h0000;
			end
			if (out_freq_o == 16'h0000)
				rev_run_q <= want_rev; // [R17]
			if (out_freq_o == target) begin
				acc_q <= 48'h0;
			end else if (acc_nx >= ramp_lim) begin
				acc_q <= acc_nx - ramp_lim;
				out_freq_o <= (out_freq_o < target) ? out_freq_o + 16'h0001
				                                    : out_freq_o - 16'h0001; // [R6]
			end else begin
				acc_q <= acc_nx;
			end
			case (st_q)
				S_IDLE: begin
					out_freq_o <= 16'h0000;
					if (run_s) begin
						pre_cnt_q <= 32'h0;
						tmr_q <= 16'h0000;
						if (start_q == 2'h2)
							st_q <= S_CALIB; // [R8]
						else if (start_q == 2'h1 && pre_t_q != 16'h0000)
							st_q <= S_PRE; // [R7] [R9]
						else
							st_q <= S_RUN; // [R6]
					end
				end
				S_CALIB: if (tmr_q >= `DSR_CALIB_TENTHS) begin
					pre_cnt_q <= 32'h0;
					tmr_q <= 16'h0000;
					st_q <= (pre_t_q != 16'h0000) ? S_PRE : S_RUN; // [R8]
				end
				S_PRE: if (tmr_q >= pre_t_q)
					st_q <= S_RUN; // [R9] [R11]
				S_RUN: if (!run_s) begin
					if (stop_q == 2'h0) begin
						st_q <= S_IDLE; // [R12]
						out_freq_o <= 16'h0000;
					end else begin
						st_q <= S_DECEL; // [R13]
					end
				end
				S_DECEL: if (run_s) begin
					st_q <= S_RUN;
				end else if (out_freq_o == 16'h0000) begin
					pre_cnt_q <= 32'h0;
					tmr_q <= 16'h0000;
					if (stop_q == 2'h2 && stp_t_q != 16'h0000 && stp_i_q != 16'h0000)
						st_q <= S_SBRK; // [R14] [R15]
					else
						st_q <= S_IDLE; // [R13]
				end
				S_SBRK: if (tmr_q >= stp_t_q)
					st_q <= S_IDLE; // [R14]
				default: st_q <= S_IDLE;
			endcase
		end
	end

	// ****************************************
	// Power-stage outputs.
	// ****************************************
	always @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			drive_en_o <= 1'b0;
			dc_brake_o <= 1'b0;
			calib_o <= 1'b0;
			brake_current_o <= 16'h0000;
			dir_rev_o <= 1'b0;
			pid_feedback_o <= 16'sd0;
		end else begin
			dir_rev_o <= rev_run_q;
			pid_feedback_o <= (src_q == 4'h7 && PID_PRESENT != 0) ? analog_input_two_i : 16'sd0; // [R3]
			calib_o <= (st_q == S_CALIB); // [R8]
			dc_brake_o <= (st_q == S_PRE && pre_i_q != 16'h0000) || st_q == S_SBRK; // [R11]
			drive_en_o <= (st_q != S_IDLE) && !(st_q == S_PRE && pre_i_q == 16'h0000); // [R12]
			case (st_q)
				S_CALIB: brake_current_o <= rated_i_q >> 1; // [R8]
				S_PRE:   brake_current_o <= pct_of(rated_i_q, pre_i_q); // [R10]
				S_SBRK:  brake_current_o <= pct_of(rated_i_q, stp_i_q); // [R15]
				default: brake_current_o <= 16'h0000;
			endcase
		end
	end
endmodule // dsr_ctrl

// ---- rtl/dsr_defines.vh ----
// Constants of the drive speed-reference and start/stop controller.
// Assumes a 10 MHz clock and an APB master with 32-bit data.
// Contract
// R1 - Source code 5 takes the larger of the two scaled analog inputs.
// R2 - Source code 6 takes the smaller of the two scaled analog inputs.
// R3 - Source code 7 uses the PID output; reserved when PID is absent.
// R4 - Source code 8 moves the master reference by up/down terminals.
// R5 - Full analog or PID range maps to min(6 x rated, upper limit).
// R6 - Start mode 0 ramps from zero speed to the commanded speed.
// R7 - Start mode 1 applies pre-start DC braking, then ramps from zero.
// R8 - Start mode 2 injects half rated current for 1 s, brakes, starts.
// R9 - Pre-start brake time 0.0..120.0 s, default 5.0; zero disables it.
// R10 - Pre-start brake current 0.0..100.0 %, default 30.0, of rated current.
// R11 - Zero pre-start current gives no braking but keeps the delay.
// R12 - Stop method 0 drops the drive at once and lets the motor coast.
// R13 - Stop method 1, the default, ramps down at the deceleration rate.
// R14 - Stop method 2 ramps down, then applies DC braking at zero.
// R15 - Stop brake time and current ranges; zero in either disables it.
// R16 - Direction code 0 both, 1 forward, 2 reverse, 3 by sign; default 1.
// R17 - Code 3 runs reverse on negative reference, forward on positive.
// R18 - Code 3 makes source 4 signed and lets negative PID reverse.
// R19 - Floor 0..60 Hz, ceiling 0..300 Hz; reference clamped between them.
// R20 - Software keeps the ceiling at or above the floor.
// R21 - Ceiling and speed settings never exceed 6 x rated nor 300 Hz.
// R22 - Parameter restore reloads the ceiling from the rated frequency.
// R23 - Priority: jog, terminal-selected input one, step speed, source.
// R24 - Ramp rates are rated frequency per acceleration or deceleration time.
// R25 - Direction and clamping apply before the ramp generator.
`ifndef DSR_DEFINES_VH
`define DSR_DEFINES_VH
`define DSR_CLK_PERIOD_NS 100
`define DSR_TENTH_NS 100000000
`define DSR_TENTH_CYCLES (`DSR_TENTH_NS / `DSR_CLK_PERIOD_NS)
`define DSR_CALIB_NS 1000000000
`define DSR_CALIB_TENTHS 16'h000A
`define DSR_OFF_CFG 8'h00
`define DSR_OFF_LIMIT 8'h04
`define DSR_OFF_MOTOR 8'h08
`define DSR_OFF_PRESTART 8'h0C
`define DSR_OFF_STOPBRK 8'h10
`define DSR_OFF_RAMP 8'h14
`define DSR_OFF_SPEED 8'h18
`define DSR_OFF_STEP 8'h1C
`define DSR_OFF_CTRL 8'h20
`define DSR_OFF_STATUS 8'h24
`define DSR_OFF_REF 8'h28
`define DSR_RST_SRC 4'h1
`define DSR_RST_START 2'h0
`define DSR_RST_STOP 2'h1
`define DSR_RST_DIR 2'h1
`define DSR_RST_FLOOR 16'h0000
`define DSR_RST_CEIL 16'h1770
`define DSR_RST_RATED_F 16'h1770
`define DSR_RST_RATED_I 16'h0064
`define DSR_RST_BRK_T 16'h0032
`define DSR_RST_BRK_I 16'h012C
`define DSR_RST_RAMP_T 16'h0064
`define DSR_RST_MASTER 16'h01F4
`define DSR_RST_JOG 16'h0258
`define DSR_MAX_FLOOR 16'h1770
`define DSR_MAX_HZ 16'h7530
`define DSR_MAX_TIME 16'h04B0
`define DSR_MAX_PCT 16'h03E8
`define DSR_FULL_PCT 16'h03E8
`define DSR_UPDN_STEP 16'h000A
`endif

// ---- verif/dsr_ctrl_props.sv ----
// Checker: port relations of dsr_ctrl.
// Assumes it is bound into dsr_ctrl and sees only its ports.
`timescale 1ns/1ps
module dsr_ctrl_props (
	// Clock and reset.
	input wire               ref_clk_i,
	input wire               rst_n_i,
	// Observed ports.
	input wire signed [15:0] analog_input_two_i,
	input wire signed [15:0] pid_feedback_o,
	input wire        [15:0] out_freq_o,
	input wire        [15:0] brake_current_o,
	input wire               drive_en_o,
	input wire               dc_brake_o,
	input wire               calib_o
);
	// ********
	// Assertions
	// ********
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_brake_at_rest: assert property (
		dc_brake_o |-> out_freq_o == 16'h0000) else $error("brake while turning");
	a_calib_at_rest: assert property (
		calib_o |-> !dc_brake_o && out_freq_o == 16'h0000) else $error("calib overlap");
	a_brake_has_current: assert property (
		dc_brake_o |-> brake_current_o != 16'h0000) else $error("brake with no current");
	a_off_no_freq: assert property (
		!drive_en_o |-> out_freq_o == 16'h0000) else $error("frequency while off");
	a_coast_drive_off: assert property (
		$past(out_freq_o) > 16'h0001 && out_freq_o == 16'h0000 |=> !drive_en_o)
		else $error("drive kept after coast");
	a_ramp_one_step: assert property (
		$changed(out_freq_o) && out_freq_o != 16'h0000 |->
		out_freq_o - $past(out_freq_o) == 16'h0001 ||
		$past(out_freq_o) - out_freq_o == 16'h0001) else $error("ramp jump");
	a_freq_limit: assert property (
		out_freq_o <= 16'h7530) else $error("frequency above limit");
	a_pid_route: assert property (
		pid_feedback_o != 16'sh0000 |-> pid_feedback_o == $past(analog_input_two_i))
		else $error("feedback not routed");
endmodule // dsr_ctrl_props

// ---- verif/dsr_ctrl_tb.sv ----
// Testbench: registers, reference sources and start/stop of dsr_ctrl.
// Assumes the design, checker and stage model are compiled first.
`timescale 1ns/1ps
module dsr_ctrl_tb;
	// ********
	// Signals
	// ********
	reg                ref_clk_i;
	reg                rst_n_i;
	reg                psel, pen, pwr, run, up, dn, clr, err, jog;
	reg         [7:0]  paddr;
	reg         [31:0] pwdata, rd, v0;
	reg  signed [15:0] ai1, ai2, pid;
	wire               pready, pslverr, drv, brk, cal, rev;
	wire signed [15:0] pfb;
	wire        [15:0] freq, bcur, bcnt, ccnt;
	wire        [31:0] prdata;
	integer            fails, samples_checked, cyc, t0;
	dsr_ctrl #(.TENTH_CYCLES(10)) u_dsr_ctrl (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
		.pready_o(pready), .pslverr_o(pslverr), .prdata_o(prdata), .run_i(run),
		.rev_i(1'b0), .jog_i(jog), .ai1_sel_i(1'b0), .step_en_i(1'b0), .speed_up_i(up),
		.speed_down_i(dn), .panel_pot_i(16'sh0000), .analog_input_one_i(ai1),
		.analog_input_two_i(ai2), .pid_out_i(pid), .pid_feedback_o(pfb), .out_freq_o(freq),
		.dir_rev_o(rev), .drive_en_o(drv), .dc_brake_o(brk), .calib_o(cal),
		.brake_current_o(bcur));
	dsr_stage_model u_dsr_stage_model (.ref_clk_i(ref_clk_i), .clr_i(clr), .dc_brake_i(brk),
		.calib_i(cal), .brake_cnt_o(bcnt), .calib_cnt_o(ccnt));
	// ********
	// Tasks
	// ********
	task chk(input [31:0] got, input [31:0] exp);
		begin
			samples_checked = samples_checked + 1;
			if (got !== exp) begin
				fails = fails + 1;
				$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [7:0] a, input [31:0] d);
		begin
			@(posedge ref_clk_i);
			psel <= 1'b1;
			pwr <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge ref_clk_i);
			pen <= 1'b1;
			@(posedge ref_clk_i);
			while (pready !== 1'b1)
				@(posedge ref_clk_i);
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			pen <= 1'b0;
		end
	endtask
	task ref_case(input [31:0] lim, input [31:0] cfg, input [15:0] exp);
		begin
			apb(1'b1, 8'h04, lim);
			apb(1'b1, 8'h00, cfg);
			repeat (3) @(posedge ref_clk_i);
			apb(1'b0, 8'h28, 32'h0);
			chk(rd[31:16], exp);
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", samples_checked, fails);
			if (fails == 0 && samples_checked > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		ref_clk_i = 1'b0;
		forever #50 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails = fails + 1;
			finish_test;
		end
	end
	// ********
	// Sequence
	// ********
	initial begin
		fails = 0;
		samples_checked = 0;
		cyc = 0;
		rst_n_i = 1'b0;
		{psel, pen, pwr, run, up, dn, err, clr} = 8'h01;
		jog = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		ai1 = 16'sh0258;
		ai2 = 16'sh012C;
		pid = 16'sh00FA;
		repeat (10) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h0000_0141);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, 32'h012C_0032);
		apb(1'b0, 8'h10, 32'h0);
		chk(rd, 32'h012C_0032);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1770_0000);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, 8'h04, 32'hFFFF_1B58);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h7530_1770);
		apb(1'b1, 8'h08, 32'h0064_03E8);
		apb(1'b1, 8'h20, 32'h1);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1770_1770);
		apb(1'b1, 8'h08, 32'h0064_1770);
		ref_case(32'h1770_0000, 32'h145, 16'h0E10);
		ref_case(32'h1770_0000, 32'h146, 16'h0708);
		ref_case(32'h1770_0000, 32'h147, 16'h05DC);
		chk(pfb, ai2);
		ref_case(32'h0BB8_0000, 32'h145, 16'h0708);
		ref_case(32'h0BB8_09C4, 32'h146, 16'h09C4);
		ref_case(32'h1770_0000, 32'h148, 16'h01F4);
		v0 = rd;
		up <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		up <= 1'b0;
		apb(1'b0, 8'h28, 32'h0);
		chk(rd[15:0] > v0[15:0], 1'b1);
		v0 = rd;
		dn <= 1'b1;
		repeat (40) @(posedge ref_clk_i);
		dn <= 1'b0;
		apb(1'b0, 8'h28, 32'h0);
		chk(rd[15:0] < v0[15:0], 1'b1);
		jog <= 1'b1;
		repeat (5) @(posedge ref_clk_i);
		apb(1'b0, 8'h28, 32'h0);
		chk(rd[31:16], 16'h0258);
		jog <= 1'b0;
		ai1 <= 16'sh0014;
		ai2 <= 16'sh0000;
		apb(1'b1, 8'h0C, 32'h012C_0003);
		apb(1'b1, 8'h00, 32'h115);
		clr <= 1'b0;
		run <= 1'b1;
		while (brk !== 1'b1)
			@(posedge ref_clk_i);
		chk(bcur, 16'h001E);
		while (freq !== 16'h0078)
			@(posedge ref_clk_i);
		chk(bcnt > 16'd19 && bcnt < 16'd32, 1'b1);
		run <= 1'b0;
		repeat (5) @(posedge ref_clk_i);
		chk({drv, freq}, 32'h0);
		apb(1'b1, 8'h10, 32'h00C8_0002);
		apb(1'b1, 8'h00, 32'h1A5);
		run <= 1'b1;
		while (cal !== 1'b1)
			@(posedge ref_clk_i);
		chk(bcur, 16'h0032);
		while (brk !== 1'b1)
			@(posedge ref_clk_i);
		chk(ccnt > 16'd89 && ccnt < 16'd102, 1'b1);
		while (freq !== 16'h0078)
			@(posedge ref_clk_i);
		run <= 1'b0;
		while (brk !== 1'b1)
			@(posedge ref_clk_i);
		chk({freq, bcur}, 32'h0000_0014);
		while (brk !== 1'b0)
			@(posedge ref_clk_i);
		apb(1'b1, 8'h0C, 32'h0000_0003);
		apb(1'b1, 8'h00, 32'h155);
		v0 = bcnt;
		t0 = cyc;
		run <= 1'b1;
		while (freq === 16'h0000)
			@(posedge ref_clk_i);
		chk(cyc - t0 > 21 && bcnt === v0[15:0], 1'b1);
		while (freq !== 16'h0078)
			@(posedge ref_clk_i);
		run <= 1'b0;
		repeat (12) @(posedge ref_clk_i);
		chk(freq > 16'h0064 && freq < 16'h0078 && drv, 1'b1);
		while (freq !== 16'h0000)
			@(posedge ref_clk_i);
		repeat (5) @(posedge ref_clk_i);
		chk(brk, 1'b0);
		apb(1'b1, 8'h00, 32'h145);
		t0 = cyc;
		run <= 1'b1;
		while (freq === 16'h0000)
			@(posedge ref_clk_i);
		chk(cyc - t0 < 12, 1'b1);
		ai1 <= -16'sh0014;
		ai2 <= 16'sh0000;
		apb(1'b1, 8'h00, 32'h344);
		while (rev !== 1'b1 || freq !== 16'h0078)
			@(posedge ref_clk_i);
		chk({rev, freq}, 32'h0001_0078);
		finish_test;
	end
endmodule // dsr_ctrl_tb
bind dsr_ctrl dsr_ctrl_props u_dsr_ctrl_props (.*);

// ---- verif/dsr_stage_model.sv ----
// Power-stage model: counts cycles of braking and calibration current.
// Assumes the controller's drive outputs on the same clock.
`timescale 1ns/1ps
module dsr_stage_model (
	// Clock and count clear.
	input  wire        ref_clk_i,
	input  wire        clr_i,
	// Drive outputs of the controller.
	input  wire        dc_brake_i,
	input  wire        calib_i,
	// Cycle counts.
	output reg  [15:0] brake_cnt_o,
	output reg  [15:0] calib_cnt_o
);
	always @(posedge ref_clk_i) begin
		brake_cnt_o <= clr_i ? 16'h0000 : brake_cnt_o + {15'h0000, dc_brake_i};
		calib_cnt_o <= clr_i ? 16'h0000 : calib_cnt_o + {15'h0000, calib_i};
	end
endmodule // dsr_stage_model
